// ==== rtl/adc_serial_pkg.sv ====
// Purpose: Shared constants for the serial readout and power-mode control.
// Assumes: Frame select active low, serial clock from the host.
// Notes:   Times are in ns; cycle counts derive from the core clock rate.

package adc_serial_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int unsigned CODE_BITS   = 12;
    localparam int unsigned CNT_W       = 5;
    localparam logic [4:0]  LEAD_ZEROS  = 5'h04;
    localparam logic [4:0]  FRAME_EDGES = 5'h10;
    localparam logic [4:0]  LAST_BIT    = 5'h0F;
    localparam logic [4:0]  EDGE_GLITCH = 5'h02;
    localparam logic [4:0]  EDGE_KEEP   = 5'h0A;
    localparam logic [4:0]  EDGE_TRACK  = 5'h0D;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_NS         = 50;
    localparam int unsigned POWERUP_NS     = 1000;
    localparam int unsigned TRISTATE_NS    = 35;
    localparam int unsigned QUIET_NS       = 60;
    localparam int unsigned ACQ_NS         = 290;
    localparam int unsigned POWERUP_CYC    = (POWERUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned PWR_W          = 6;

    // Power state of the analog core
    typedef enum logic [1:0] {
        PWR_NORMAL,
        PWR_ASLEEP,
        PWR_WAKING
    } pwr_state_e;

endpackage : adc_serial_pkg

// ==== rtl/frame_if.sv ====
// Purpose: Carrier between the serial-clock side and the power controller.
// Assumes: Toggles change only on serial clock falling edges.
// Notes:   Every signal here crosses a clock domain at its receiver.
`timescale 1ns/10ps
`default_nettype none

interface frame_if;
    logic reached_glitch_tgl;   // Flips at the second falling edge
    logic reached_keep_tgl;     // Flips at the tenth falling edge
    logic asleep;               // Core is powered down

    modport link (output reached_glitch_tgl, output reached_keep_tgl, input asleep);
    modport ctrl (input reached_glitch_tgl, input reached_keep_tgl, output asleep);
endinterface : frame_if

`default_nettype wire

// ==== rtl/sync_bits.sv ====
// Purpose: Three-stage synchroniser with agreement filter, one per bit.
// Assumes: Inputs are levels from another domain or a pin.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none

module sync_bits #(
    parameter int unsigned   WIDTH   = 1,
    parameter logic [31:0]   RST_VAL = 32'h0000_0000
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output var  logic [WIDTH-1:0] dout
);

    // ------------------------------------------------------------
    // Per-bit chain
    // ------------------------------------------------------------
    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
        logic s1_r;
        logic s2_r;
        logic s3_r;
        logic f_r;
        wire  agree = (s2_r == s3_r);

        // Change accepted once stages two and three agree
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                s1_r <= RST_VAL[i];
                s2_r <= RST_VAL[i];
                s3_r <= RST_VAL[i];
                f_r  <= RST_VAL[i];
            end else begin
                s1_r <= din[i];
                s2_r <= s1_r;
                s3_r <= s2_r;
                f_r  <= agree ? s3_r : f_r;
            end
        end
        assign dout[i] = f_r;
    end

endmodule : sync_bits

`default_nettype wire

// ==== rtl/power_ctrl.sv ====
// Purpose: Decides normal or power-down mode from where the select rises.
// Assumes: Frame select is a pin; edge toggles come from the serial side.
// Notes:   Decision waits for the synchronised select, a few core cycles.
`timescale 1ns/10ps
`default_nettype none

module power_ctrl #(
    parameter int unsigned POWERUP_CYCLES = adc_serial_pkg::POWERUP_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Frame select pin
    input  wire logic cs_b,
    // Serial side
    frame_if.ctrl     fr,
    // Core power status
    output var  logic bias_on,
    output var  logic settled
);

    // ------------------------------------------------------------
    // Crossing
    // ------------------------------------------------------------
    logic [2:0] sync_q;

    sync_bits #(.WIDTH(3), .RST_VAL(32'h0000_0001)) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   ({fr.reached_keep_tgl, fr.reached_glitch_tgl, cs_b}),
        .dout  (sync_q)
    );

    wire cs_b_s = sync_q[0];
    wire t2_s   = sync_q[1];
    wire t10_s  = sync_q[2];

    // ------------------------------------------------------------
    // Edge detection and frame snapshot
    // ------------------------------------------------------------
    logic                         cs_b_d_r;
    logic                         t2_snap_r;
    logic                         t10_snap_r;
    adc_serial_pkg::pwr_state_e   state_r;
    adc_serial_pkg::pwr_state_e   state_nxt;
    logic [adc_serial_pkg::PWR_W-1:0] pwr_cnt_r;
    logic [adc_serial_pkg::PWR_W-1:0] pwr_cnt_nxt;
    logic                         bias_r;
    logic                         settled_r;

    wire cs_fall   = cs_b_d_r & ~cs_b_s;
    wire cs_rise   = ~cs_b_d_r & cs_b_s;
    wire got_glitch = (t2_s != t2_snap_r);     // Second falling edge seen
    wire got_keep   = (t10_s != t10_snap_r);   // Tenth falling edge seen

    // Snapshot toggles at frame start so each frame is judged alone
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_b_d_r   <= 1'b1;
            t2_snap_r  <= 1'b0;
            t10_snap_r <= 1'b0;
        end else begin
            cs_b_d_r   <= cs_b_s;
            t2_snap_r  <= cs_fall ? t2_s : t2_snap_r;
            t10_snap_r <= cs_fall ? t10_s : t10_snap_r;
        end
    end

    // ------------------------------------------------------------
    // Mode decision
    // ------------------------------------------------------------
    // Mode chosen at select rise by how many falling edges passed
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            adc_serial_pkg::PWR_NORMAL: begin
                if (cs_rise && got_glitch && !got_keep) begin
                    state_nxt = adc_serial_pkg::PWR_ASLEEP;
                end
            end
            adc_serial_pkg::PWR_ASLEEP: begin
                if (cs_fall) begin
                    state_nxt = adc_serial_pkg::PWR_WAKING;
                end
            end
            adc_serial_pkg::PWR_WAKING: begin
                if (cs_rise) begin
                    state_nxt = got_keep ? adc_serial_pkg::PWR_NORMAL
                                         : adc_serial_pkg::PWR_ASLEEP;
                end
            end
        endcase
    end
    // Rise before the second edge leaves normal unchanged; from waking it returns to asleep
    // Rise after the tenth edge stays in normal

    // Settle counter runs while bias is on, clears when asleep
    assign pwr_cnt_nxt = (state_nxt == adc_serial_pkg::PWR_ASLEEP) ? '0 :
                         (pwr_cnt_r == adc_serial_pkg::PWR_W'(POWERUP_CYCLES)) ? pwr_cnt_r :
                         adc_serial_pkg::PWR_W'(pwr_cnt_r + 1'b1);

    // State, power and settle flags
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r   <= adc_serial_pkg::PWR_NORMAL;
            pwr_cnt_r <= '0;
            bias_r    <= 1'b1;
            settled_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            pwr_cnt_r <= pwr_cnt_nxt;
            bias_r    <= (state_nxt != adc_serial_pkg::PWR_ASLEEP);
            settled_r <= (pwr_cnt_nxt == adc_serial_pkg::PWR_W'(POWERUP_CYCLES));
        end
    end

    assign fr.asleep = (state_r == adc_serial_pkg::PWR_ASLEEP);
    assign bias_on   = bias_r;
    assign settled   = settled_r;

endmodule : power_ctrl

`default_nettype wire

// ==== rtl/adc_serial_top.sv ====
// Purpose: Serial readout of a 12-bit result with power-mode control.
// Assumes: Host drives frame select and serial clock; code is stable
//          from the converter core by the first falling edge.
// Notes:   Frame logic is cleared asynchronously by the select, since
//          the serial clock may stop as soon as the frame ends.
`timescale 1ns/10ps
`default_nettype none

module adc_serial_top #(
    parameter int unsigned POWERUP_CYCLES = adc_serial_pkg::POWERUP_CYC
) (
    // Core clock and reset
    input  wire logic                                clk,
    input  wire logic                                rst_b,
    // Serial link from the host
    input  wire logic                                sclk,
    input  wire logic                                cs_b,
    output var  logic                                serial_result_out,
    output var  logic                                serial_result_oe,
    // Converter core
    input  wire logic [adc_serial_pkg::CODE_BITS-1:0] conv_code,
    output var  logic                                track_hold,
    output var  logic                                bias_on,
    output var  logic                                settled
);

    // ------------------------------------------------------------
    // Frame clear
    // ------------------------------------------------------------
    // Select high clears the frame at once
    wire frame_clr_b = rst_b & ~cs_b;

    frame_if fr ();

    // ------------------------------------------------------------
    // Edge counter and shifter, serial clock falling edge
    // ------------------------------------------------------------
    logic [adc_serial_pkg::CNT_W-1:0]     cnt_r;
    logic [adc_serial_pkg::CNT_W-1:0]     cnt_nxt;
    logic [adc_serial_pkg::CODE_BITS-1:0] code_r;
    logic [adc_serial_pkg::CODE_BITS-1:0] code_nxt;
    logic                                 data_r;
    logic                                 data_nxt;
    logic                                 done_r;
    logic                                 t2_r;
    logic                                 t10_r;
    logic                                 track_r;
    logic                                 asleep_s;

    wire [adc_serial_pkg::CNT_W-1:0] bit_idx = adc_serial_pkg::LAST_BIT - cnt_nxt;
    wire in_code = (cnt_nxt >= adc_serial_pkg::LEAD_ZEROS) &&
                   (cnt_nxt <  adc_serial_pkg::FRAME_EDGES);

    // Count saturates so later edges in a long frame do nothing
    assign cnt_nxt  = (cnt_r == adc_serial_pkg::FRAME_EDGES) ? cnt_r :
                      adc_serial_pkg::CNT_W'(cnt_r + 1'b1);
    // Code captured on the first edge, ahead of its first use
    assign code_nxt = (cnt_r == '0) ? conv_code : code_r;
    // Zeros first, then MSB down to LSB, launched per falling edge
    assign data_nxt = in_code ? code_r[bit_idx[3:0]] : 1'b0;
    wire   edge_new = (cnt_nxt != cnt_r);

    // Frame state, cleared while select is high
    always_ff @(negedge sclk or negedge frame_clr_b) begin
        if (!frame_clr_b) begin
            cnt_r  <= '0;
            code_r <= '0;
            data_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            code_r <= code_nxt;
            data_r <= data_nxt;
            done_r <= (cnt_nxt == adc_serial_pkg::FRAME_EDGES);
        end
    end

    // Edge-reached toggles survive the frame clear for the controller
    always_ff @(negedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            t2_r  <= 1'b0;
            t10_r <= 1'b0;
        end else begin
            t2_r  <= t2_r ^ (edge_new && cnt_nxt == adc_serial_pkg::EDGE_GLITCH);
            t10_r <= t10_r ^ (edge_new && cnt_nxt == adc_serial_pkg::EDGE_KEEP);
        end
    end

    assign fr.reached_glitch_tgl = t2_r;
    assign fr.reached_keep_tgl   = t10_r;

    // ------------------------------------------------------------
    // Track-and-hold, serial clock rising edge
    // ------------------------------------------------------------
    // Asleep flag is quasi-static during a frame; synced on this clock
    sync_bits #(.WIDTH(1), .RST_VAL(32'h0000_0000)) u_sleep_sync (
        .clk   (sclk),
        .rst_b (rst_b),
        .din   (fr.asleep),
        .dout  (asleep_s)
    );

    // Back to track after the thirteenth fall, or when waking once the synced asleep_s is seen, a few rising edges in
    always_ff @(posedge sclk or negedge frame_clr_b) begin
        if (!frame_clr_b) begin
            track_r <= 1'b0;
        end else begin
            track_r <= track_r | (cnt_r >= adc_serial_pkg::EDGE_TRACK)
                               | asleep_s;
        end
    end

    // ------------------------------------------------------------
    // Power controller
    // ------------------------------------------------------------
    power_ctrl #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_pwr (
        .clk     (clk),
        .rst_b   (rst_b),
        .cs_b    (cs_b),
        .fr      (fr.ctrl),
        .bias_on (bias_on),
        .settled (settled)
    );

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    // Enable gated by the raw select so release needs no clock edge
    assign serial_result_oe  = ~cs_b & ~done_r;
    assign serial_result_out = data_r;
    assign track_hold        = ~cs_b & ~track_r;

endmodule : adc_serial_top

`default_nettype wire

// ==== dv/adc_serial_assertions.sv ====
// Purpose: Port checker for serial readout and power modes.
// Assumes: Serial clock idles high and runs only within frames.
// Notes:   Keeps its own fall count; the select wipes the design's.
`timescale 1ns/10ps
`default_nettype none

module adc_serial_assertions #(
    parameter int unsigned POWERUP_CYCLES = 20
) (
    // Clocks and reset
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        sclk,
    // Pins and core
    input wire logic        cs_b,
    input wire logic        serial_result_out,
    input wire logic        serial_result_oe,
    input wire logic [11:0] conv_code,
    input wire logic        track_hold,
    input wire logic        bias_on,
    input wire logic        settled
);
    logic [4:0]  falls_r;
    logic [11:0] code_r;
    logic        cs_q_r;
    logic        sleepy_r;

    // Falls of this frame, cleared at once by a high select
    always_ff @(negedge sclk or negedge rst_b or posedge cs_b) begin
        if (!rst_b) begin
            falls_r <= 5'h00;
        end else if (cs_b) begin
            falls_r <= 5'h00;
        end else if (falls_r != 5'h10) begin
            falls_r <= falls_r + 5'h01;
        end
    end

    // Code as the design takes it, at the first fall
    always_ff @(negedge sclk) begin
        if (falls_r == 5'h00) begin
            code_r <= conv_code;
        end
    end

    // Mode when the frame opened; decisions depend on it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_q_r   <= 1'b1;
            sleepy_r <= 1'b0;
        end else begin
            cs_q_r   <= cs_b;
            sleepy_r <= (cs_q_r && !cs_b) ? !settled : sleepy_r;
        end
    end

    idle_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
        cs_b |-> !serial_result_oe && !serial_result_out) else $error("drive while idle");
    frame_start_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(cs_b) |-> serial_result_oe && (track_hold || !settled)) else $error("bad start");
    lead_zeros_a: assert property (@(posedge sclk) disable iff (!rst_b)
        !cs_b && falls_r < 5'h04 |-> serial_result_oe && !serial_result_out)
        else $error("leading zero wrong");
    data_bits_a: assert property (@(posedge sclk) disable iff (!rst_b)
        !cs_b && falls_r >= 5'h04 && falls_r <= 5'h0F
        |-> serial_result_out == code_r[4'hF - falls_r[3:0]]) else $error("data bit wrong");
    release_a: assert property (@(posedge sclk) disable iff (!rst_b)
        falls_r == 5'h10 |-> !serial_result_oe) else $error("no release at last fall");
    track_back_a: assert property (@(negedge sclk) disable iff (!rst_b)
        !cs_b && falls_r >= 5'h0D |-> !track_hold) else $error("still holding");
    keep_power_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(cs_b) && ($past(falls_r) >= 5'h0A || (!sleepy_r && $past(falls_r) < 5'h02))
        |=> bias_on [*8]) else $error("power lost");
    sleep_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(cs_b) && $past(falls_r) < 5'h0A && ($past(falls_r) >= 5'h02 || sleepy_r)
        |-> ##[1:12] !bias_on) else $error("no power-down");
    wake_up_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(cs_b) && !bias_on |-> ##[1:8] bias_on) else $error("no wake");
endmodule : adc_serial_assertions

bind adc_serial_top adc_serial_assertions #(.POWERUP_CYCLES(POWERUP_CYCLES)) chk (
    .clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
    .conv_code(conv_code), .track_hold(track_hold), .bias_on(bias_on), .settled(settled));

`default_nettype wire

// ==== dv/adc_host_model.sv ====
// Purpose: Host serial master owning select and serial clock.
// Assumes: Serial clock idles high; bits read on rising edges.
// Notes:   A released line reads as the inverse of its last value.
`timescale 1ns/10ps
`default_nettype none

module adc_host_model (
    // Core clock for select timing
    input  wire logic clk,
    // Serial link
    input  wire logic serial_result_out,
    input  wire logic serial_result_oe,
    output var  logic sclk,
    output var  logic cs_b
);
    logic line_r = 1'b0;

    initial begin
        sclk = 1'b1;
        cs_b = 1'b1;
    end

    // Flipping a released line keeps a stale bit from passing
    task automatic grab(output logic b);
        line_r = serial_result_oe ? serial_result_out : !line_r;
        b = line_r;
    endtask : grab

    // Frame of n falls at half period hp; clock still outside it
    task automatic frame(input int n, input int hp, output logic [15:0] word,
                         output logic oe_end);
        word = 16'h0000;
        @(posedge clk);
        #2;
        cs_b = 1'b0;
        #(hp);
        grab(word[15]);
        for (int k = 1; k <= n; k++) begin
            sclk = 1'b0;
            #(hp);
            sclk = 1'b1;
            if (k < 16) grab(word[15-k]);
            #(hp);
        end
        oe_end = serial_result_oe;
        #250;
        @(posedge clk);
        #2;
        cs_b = 1'b1;
    endtask : frame
endmodule : adc_host_model

`default_nettype wire

// ==== dv/sar_adc_serial_readout_power_modes_test.sv ====
// Purpose: Self-checking bench for serial readout and power modes.
// Assumes: Host model owns serial clock and select.
// Notes:   Short power-up count keeps frame settling quick.
`timescale 1ns/10ps
`default_nettype none

module sar_adc_serial_readout_power_modes_test;
    localparam int unsigned PU = 3;
    logic        clk;
    logic        rst_b;
    logic        sclk;
    logic        cs_b;
    logic        dout;
    logic        oe;
    logic        track_hold;
    logic        bias_on;
    logic        settled;
    logic [11:0] conv_code;
    logic [15:0] word;
    logic        oe_end;
    int          bad_count = 0;
    int          n_tests = 0;
    int          cycles = 0;
    int          seed = 44;
    int          asleep = 0;
    int          plan [14] = '{16, 5, 16, 1, 12, 0, 9, 2, 1, 10, 15, 13, 3, 16};

    adc_serial_top #(.POWERUP_CYCLES(PU)) DUT (
        .clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
        .serial_result_out(dout), .serial_result_oe(oe), .conv_code(conv_code),
        .track_hold(track_hold), .bias_on(bias_on), .settled(settled));
    adc_host_model host (.clk(clk), .serial_result_out(dout), .serial_result_oe(oe),
        .sclk(sclk), .cs_b(cs_b));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t word %h not %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t flag %b not %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic tally_and_finish;
        if (bad_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // One frame against the model: bits, release, resulting mode
    task automatic run(input int n, input int hp);
        logic [15:0] full;
        logic [15:0] mask;
        @(posedge clk);
        #2;
        conv_code = 12'($random(seed));
        full = {4'h0, conv_code};
        mask = ~(16'hFFFF >> (n + 1));
        // Hold is watched beside the frame; it has no other comparison
        fork
            host.frame(n, hp, word, oe_end);
            begin
                @(negedge cs_b);
                #5;
                check_bit(track_hold, 1'b1);
                if (n >= 14) begin
                    repeat (14) @(negedge sclk);
                    #1;
                    check_bit(track_hold, 1'b0);
                end
            end
        join
        check_word(word & mask, full & mask);
        check_bit(oe_end, n < 16);
        #30;
        check_bit(oe, 1'b0);
        if (asleep != 0) asleep = (n < 10);
        else if (n >= 2 && n < 10) asleep = 1;
        repeat (14) @(posedge clk);
        #2;
        check_bit(bias_on, asleep == 0);
        check_bit(settled, asleep == 0);
    endtask : run

    // Hang guard; a full run needs about 800 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            $display("MISMATCH %0t run timed out", $time);
            tally_and_finish();
        end
    end

    // Reset, fixed table of frame lengths, then random ones
    initial begin
        rst_b = 1'b0;
        conv_code = 12'h000;
        repeat (8) @(posedge clk);
        #2;
        rst_b = 1'b1;
        repeat (10) @(posedge clk);
        #2;
        check_bit(settled, 1'b1);
        foreach (plan[i]) run(plan[i], 32);
        for (int i = 0; i < 10; i++) run({$random(seed)} % 17, 32);
        tally_and_finish();
    end
endmodule : sar_adc_serial_readout_power_modes_test

`default_nettype wire
